// file: network_node_address_select.sv
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// How it works
// [R1] node ids one to 127 only are valid
// [R2] node id zero never goes online
// [R3] node id is stored high three, switch low four
// [R4] changes take effect only after power cycle
// [R5] rate positions 0-7 decoded, 8 and 9 reserved
// [R6] integrator keeps node ids unique on a network
// [R7] ip position zero gives 10.10.10.10 / 255.0.0.0
// [R8] positions 1 to E read the stored table
// [R9] table addresses use 255.255.0.0 mask
// [R10] position F requests address from dhcp
// [R11] commands on udp 7775 and tcp 7776
// [R12] udp and tcp handled the same way
// [R13] first command records owner ip and port
// [R14] other ips dropped once owner recorded
// [R15] owner lock cleared only by power-down
// [R16] auto crossover on direct cable
// [R17] switches sampled once after power-up
module network_node_address_select
  import node_select_pkg::*;
#(
  parameter int MDIX_DWELL_CYCLES = MDIX_DWELL_DEF
) (
  // clock and power-up reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite slave
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  input  wire logic [AXI_AW-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  // rotary switch pins and stored high node bits
  input  wire logic [3:0]        node_address_switch,
  input  wire logic [3:0]        bit_rate_switch,
  input  wire logic [3:0]        ip_address_switch,
  input  wire logic [2:0]        stored_node_high,
  // can identity
  output var  logic [6:0]        node_id,
  output var  logic              node_online,
  output var  logic              bit_rate_valid,
  output var  logic [13:0]       can_bit_cycles,
  // ip configuration and dhcp client
  output var  logic [31:0]       ip_addr,
  output var  logic [31:0]       ip_mask,
  output var  logic              ip_config_valid,
  output var  logic              dhcp_request,
  input  wire logic              dhcp_offer_valid,
  input  wire logic [31:0]       dhcp_offer_ip,
  input  wire logic [31:0]       dhcp_offer_mask,
  // command packet filter
  input  wire logic              rx_valid,
  input  wire logic              rx_tcp,
  input  wire logic [31:0]       rx_src_ip,
  input  wire logic [15:0]       rx_src_port,
  input  wire logic [15:0]       rx_dst_port,
  output var  logic              cmd_valid,
  output var  logic              cmd_tcp,
  output var  logic              cmd_drop,
  output var  logic              owner_valid,
  output var  logic [31:0]       resp_ip,
  output var  logic [15:0]       resp_port,
  // phy pairing
  input  wire logic              phy_link_ok,
  output var  logic              mdix_swap,
  output var  logic              link_up
);

  localparam int DW = $clog2(MDIX_DWELL_CYCLES + 1);

  typedef enum logic {boot_settle, boot_run} boot_t;
  typedef enum logic [1:0] {mdi_hunt, mdix_hunt, phy_linked} phy_t;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] node_sw_m, node_sw_s, rate_sw_m, rate_sw_s, ip_sw_m, ip_sw_s;
  logic       link_m, link_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      node_sw_m <= 4'h0;
      node_sw_s <= 4'h0;
      rate_sw_m <= 4'h0;
      rate_sw_s <= 4'h0;
      ip_sw_m   <= 4'h0;
      ip_sw_s   <= 4'h0;
      link_m    <= 1'b0;
      link_s    <= 1'b0;
    end else begin
      node_sw_m <= node_address_switch;
      node_sw_s <= node_sw_m;
      rate_sw_m <= bit_rate_switch;
      rate_sw_s <= rate_sw_m;
      ip_sw_m   <= ip_address_switch;
      ip_sw_s   <= ip_sw_m;
      link_m    <= phy_link_ok;
      link_s    <= link_m;
    end
  end

  // ****************************************
  // power-up sampling
  // ****************************************
  boot_t      boot;
  logic [3:0] settle_cnt;
  logic       latch_now;
  logic       running;
  logic       run_d;
  logic [3:0] rate_sel;
  logic [3:0] ip_pos;

  assign latch_now = (boot == boot_settle) && (settle_cnt == SETTLE_CYCLES - 4'h1);
  assign running   = (boot == boot_run);

  // settle lets the synchronisers fill before the one and only sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot       <= boot_settle;
      settle_cnt <= 4'h0;
      run_d      <= 1'b0;
    end else begin
      run_d <= running;
      case (boot)
        boot_settle: begin
          if (latch_now) begin
            boot <= boot_run;
          end else begin
            settle_cnt <= settle_cnt + 4'h1;
          end
        end
        default: boot <= boot_run;
      endcase
    end
  end

  // later switch or stored changes are ignored until the next reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      node_id  <= 7'h00;
      rate_sel <= 4'h0;
      ip_pos   <= 4'h0;
    end else if (latch_now) begin
      node_id  <= {stored_node_high, node_sw_s}; // [R3] [R4] [R17]
      rate_sel <= rate_sw_s; // [R17]
      ip_pos   <= ip_sw_s; // [R17]
    end
  end

  // ****************************************
  // can identity
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      node_online    <= 1'b0;
      bit_rate_valid <= 1'b0;
      can_bit_cycles <= 14'h0000;
    end else begin
      node_online    <= running && node_id >= NODE_ID_MIN && node_id <= NODE_ID_MAX; // [R1] [R2]
      bit_rate_valid <= running && rate_sel < RATE_RESERVED; // [R5]
      can_bit_cycles <= running ? can_cycles(rate_sel) : 14'h0000; // [R5]
    end
  end

  // ****************************************
  // ip selection
  // ****************************************
  logic        we;
  logic        re_a;
  logic [31:0] tbl_bus_q, tbl_sel_q;
  logic [7:0]  aw_addr_q, ar_addr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  ip_table_mem #(.DATA_W(32), .ADDR_W(4)) u_table (
    .clk     (aclk),
    .rst_n   (aresetn),
    .we      (we),
    .waddr   (aw_addr_q[5:2]),
    .wdata   (wdata_q),
    .wstrb   (wstrb_q),
    .re_a    (re_a),
    .raddr_a (araddr[5:2]),
    .rdata_a (tbl_bus_q),
    .raddr_b (ip_pos),
    .rdata_b (tbl_sel_q)
  );

  // run_d waits one cycle so the table port has read the latched position
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ip_addr         <= 32'h00000000;
      ip_mask         <= 32'h00000000;
      ip_config_valid <= 1'b0;
      dhcp_request    <= 1'b0;
    end else if (run_d) begin
      if (ip_pos == IP_POS_RECOVERY) begin
        ip_addr         <= RECOVERY_IP; // [R7]
        ip_mask         <= RECOVERY_MASK; // [R7]
        ip_config_valid <= 1'b1;
      end else if (ip_pos == IP_POS_DHCP) begin
        if (dhcp_request && dhcp_offer_valid) begin
          ip_addr         <= dhcp_offer_ip; // [R10]
          ip_mask         <= dhcp_offer_mask; // [R10]
          ip_config_valid <= 1'b1;
          dhcp_request    <= 1'b0;
        end else if (!ip_config_valid) begin
          dhcp_request <= 1'b1; // [R10]
        end
      end else begin
        ip_addr         <= tbl_sel_q; // [R8]
        ip_mask         <= TABLE_MASK; // [R9]
        ip_config_valid <= 1'b1;
      end
    end
  end

  // ****************************************
  // command owner filter
  // ****************************************
  logic is_cmd;

  assign is_cmd = rx_tcp ? (rx_dst_port == TCP_CMD_PORT) : (rx_dst_port == UDP_CMD_PORT); // [R11]

  // no write path reaches owner_valid: only the power-up reset clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      owner_valid <= 1'b0; // [R15]
      resp_ip     <= 32'h00000000;
      resp_port   <= 16'h0000;
      cmd_valid   <= 1'b0;
      cmd_drop    <= 1'b0;
      cmd_tcp     <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      cmd_drop  <= 1'b0;
      if (rx_valid && is_cmd && ip_config_valid) begin
        cmd_tcp <= rx_tcp; // [R12]
        if (!owner_valid) begin
          owner_valid <= 1'b1; // [R13]
          resp_ip     <= rx_src_ip; // [R13]
          resp_port   <= rx_src_port; // [R13]
          cmd_valid   <= 1'b1;
        end else if (rx_src_ip == resp_ip) begin
          cmd_valid <= 1'b1; // [R12]
        end else begin
          cmd_drop <= 1'b1; // [R14]
        end
      end
    end
  end

  // ****************************************
  // auto crossover
  // ****************************************
  phy_t          phy_state;
  logic [DW-1:0] dwell_cnt;
  logic          dwell_end;

  assign dwell_end = (dwell_cnt == DW'(MDIX_DWELL_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phy_state <= mdi_hunt;
      dwell_cnt <= '0;
      mdix_swap <= 1'b0;
      link_up   <= 1'b0;
    end else begin
      case (phy_state)
        phy_linked: begin
          if (!link_s) begin
            link_up   <= 1'b0;
            phy_state <= mdix_swap ? mdix_hunt : mdi_hunt;
          end
        end
        default: begin
          if (link_s) begin
            link_up   <= 1'b1;
            dwell_cnt <= '0;
            phy_state <= phy_linked;
          end else if (dwell_end) begin
            dwell_cnt <= '0;
            mdix_swap <= ~mdix_swap; // [R16]
            phy_state <= (phy_state == mdi_hunt) ? mdix_hunt : mdi_hunt; // [R16]
          end else begin
            dwell_cnt <= dwell_cnt + DW'(1);
          end
        end
      endcase
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  function automatic logic table_hit(input logic [7:0] a);
    table_hit = ((a & TABLE_SEL_MASK) == OFF_TABLE_BASE)
             && (a[5:2] != IP_POS_RECOVERY) && (a[5:2] != IP_POS_DHCP);
  endfunction : table_hit

  logic aw_hold, w_hold, wr_fire, rd_wait;

  assign wr_fire = aw_hold && w_hold && !bvalid;
  assign we      = wr_fire && table_hit(aw_addr_q);
  assign re_a    = arvalid && arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b0;
      aw_hold   <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (awvalid && awready) begin
      aw_addr_q <= awaddr;
      aw_hold   <= 1'b1;
      awready   <= 1'b0;
    end else if (wr_fire) begin
      aw_hold <= 1'b0;
    end else if (!aw_hold) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready  <= 1'b0;
      w_hold  <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (wvalid && wready) begin
      wdata_q <= wdata;
      wstrb_q <= wstrb;
      w_hold  <= 1'b1;
      wready  <= 1'b0;
    end else if (wr_fire) begin
      w_hold <= 1'b0;
    end else if (!w_hold) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= table_hit(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic        rd_err;

  always_comb begin
    status_word = 32'h00000000;
    status_word[ST_NODE_LSB +: 7] = node_id;
    status_word[ST_NODE_OK]       = node_online;
    status_word[ST_RATE_LSB +: 4] = rate_sel;
    status_word[ST_RATE_OK]       = bit_rate_valid;
    status_word[ST_IP_LSB +: 4]   = ip_pos;
    status_word[ST_DHCP]          = dhcp_request;
    status_word[ST_OWNER]         = owner_valid;
    status_word[ST_MDIX]          = mdix_swap;
    status_word[ST_LINK]          = link_up;
    status_word[ST_RUN]           = running;
  end

  always_comb begin
    rd_err = 1'b0;
    rd_mux = 32'h00000000;
    if (ar_addr_q == OFF_STATUS) begin
      rd_mux = status_word;
    end else if (ar_addr_q == OFF_OWNER_IP) begin
      rd_mux = resp_ip;
    end else if (ar_addr_q == OFF_OWNER_PORT) begin
      rd_mux = {16'h0000, resp_port};
    end else if (ar_addr_q == OFF_IP_ADDR) begin
      rd_mux = ip_addr;
    end else if (ar_addr_q == OFF_IP_MASK) begin
      rd_mux = ip_mask;
    end else if (table_hit(ar_addr_q)) begin
      rd_mux = tbl_bus_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready   <= 1'b0;
      ar_addr_q <= 8'h00;
      rd_wait   <= 1'b0;
      rvalid    <= 1'b0;
      rdata     <= 32'h00000000;
      rresp     <= RESP_OKAY;
    end else if (arvalid && arready) begin
      ar_addr_q <= araddr;
      arready   <= 1'b0;
      rd_wait   <= 1'b1;
    end else if (rd_wait) begin
      rd_wait <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_mux;
      rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid) begin
      if (rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end else begin
      arready <= 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_node_zero_off: assert property (node_online |-> node_id != 7'h00) // [R2]
    else $error("node online with id zero");
  a_node_range: assert property ($past(running) && node_id != 7'h00 |-> node_online) // [R1]
    else $error("valid node id not online");
  a_node_compose: assert property (latch_now |=> node_id == {$past(stored_node_high), $past(node_sw_s)}) // [R3]
    else $error("node id not composed from stored and switch bits");
  a_latch_hold: assert property (running && $past(running) |-> $stable(node_id) && $stable(rate_sel) && $stable(ip_pos)) // [R4] [R17]
    else $error("latched settings changed after power-up");
  a_rate_decode: assert property ($past(running) && rate_sel == 4'h7 |-> can_bit_cycles == 14'd8000 && bit_rate_valid) // [R5]
    else $error("12.5k rate decode wrong");
  a_rate_reserved: assert property ($past(running) && rate_sel >= 4'h8 |-> !bit_rate_valid) // [R5]
    else $error("reserved rate accepted");
  a_recovery_ip: assert property (run_d && ip_pos == 4'h0 |=> ip_addr == 32'h0a0a0a0a && ip_mask == 32'hff000000) // [R7]
    else $error("recovery address wrong");
  a_table_mask: assert property (run_d && ip_pos != 4'h0 && ip_pos != 4'hf |=> ip_mask == 32'hffff0000 ##0 ip_addr == $past(tbl_sel_q)) // [R8] [R9]
    else $error("table entry or mask wrong");
  a_dhcp_only_f: assert property (dhcp_request |-> ip_pos == 4'hf && !ip_config_valid) // [R10]
    else $error("dhcp requested off position f");
  a_port_accept: assert property (cmd_valid |-> $past(rx_dst_port) == ($past(rx_tcp) ? 16'd7776 : 16'd7775)) // [R11]
    else $error("command accepted on wrong port");
  a_owner_record: assert property (rx_valid && is_cmd && ip_config_valid && !owner_valid |=> owner_valid && cmd_valid && resp_ip == $past(rx_src_ip) && resp_port == $past(rx_src_port)) // [R13]
    else $error("owner not recorded on first command");
  a_foreign_drop: assert property (rx_valid && is_cmd && ip_config_valid && owner_valid && rx_src_ip != resp_ip |=> cmd_drop && !cmd_valid) // [R14]
    else $error("foreign command not dropped");
  a_owner_sticky: assert property (owner_valid |=> owner_valid && $stable(resp_ip) && $stable(resp_port)) // [R15]
    else $error("owner lock released");
  a_mdix_swap: assert property (phy_state != phy_linked && !link_s && dwell_end |=> mdix_swap != $past(mdix_swap)) // [R16]
    else $error("pairing not swapped after dwell");

endmodule : network_node_address_select

`default_nettype wire

// file: node_select_pkg.sv
package node_select_pkg;

  // ****************************************
  // bus map
  // ****************************************
  localparam int           AXI_AW         = 8;
  localparam logic [7:0]   OFF_STATUS     = 8'h00;
  localparam logic [7:0]   OFF_OWNER_IP   = 8'h04;
  localparam logic [7:0]   OFF_OWNER_PORT = 8'h08;
  localparam logic [7:0]   OFF_IP_ADDR    = 8'h0c;
  localparam logic [7:0]   OFF_IP_MASK    = 8'h10;
  localparam logic [7:0]   OFF_TABLE_BASE = 8'h40;
  localparam logic [7:0]   TABLE_SEL_MASK = 8'hc3;
  localparam logic [1:0]   RESP_OKAY      = 2'h0;
  localparam logic [1:0]   RESP_SLVERR    = 2'h2;

  // status word fields
  localparam int ST_NODE_LSB   = 0;
  localparam int ST_NODE_OK    = 7;
  localparam int ST_RATE_LSB   = 8;
  localparam int ST_RATE_OK    = 12;
  localparam int ST_IP_LSB     = 13;
  localparam int ST_DHCP       = 17;
  localparam int ST_OWNER      = 18;
  localparam int ST_MDIX       = 19;
  localparam int ST_LINK       = 20;
  localparam int ST_RUN        = 21;

  // ****************************************
  // identity and addressing
  // ****************************************
  localparam logic [6:0]   NODE_ID_MIN     = 7'h01;
  localparam logic [6:0]   NODE_ID_MAX     = 7'h7f;
  localparam logic [3:0]   RATE_RESERVED   = 4'h8;
  localparam logic [3:0]   IP_POS_RECOVERY = 4'h0;
  localparam logic [3:0]   IP_POS_DHCP     = 4'hf;
  localparam logic [31:0]  RECOVERY_IP     = 32'h0a0a0a0a;
  localparam logic [31:0]  RECOVERY_MASK   = 32'hff000000;
  localparam logic [31:0]  TABLE_MASK      = 32'hffff0000;
  localparam logic [15:0]  UDP_CMD_PORT    = 16'h1e5f;
  localparam logic [15:0]  TCP_CMD_PORT    = 16'h1e60;

  // ****************************************
  // timing
  // ****************************************
  localparam int           CLK_MHZ        = 100;
  localparam int           CLK_HZ         = CLK_MHZ * 1000000;
  localparam logic [3:0]   SETTLE_CYCLES  = 4'h8;
  localparam int           MDIX_DWELL_US  = 100;
  localparam int           MDIX_DWELL_DEF = MDIX_DWELL_US * CLK_MHZ;
  localparam logic [13:0]  CAN_CYC_1M     = 14'(CLK_HZ / 1000000);
  localparam logic [13:0]  CAN_CYC_800K   = 14'(CLK_HZ / 800000);
  localparam logic [13:0]  CAN_CYC_500K   = 14'(CLK_HZ / 500000);
  localparam logic [13:0]  CAN_CYC_250K   = 14'(CLK_HZ / 250000);
  localparam logic [13:0]  CAN_CYC_125K   = 14'(CLK_HZ / 125000);
  localparam logic [13:0]  CAN_CYC_50K    = 14'(CLK_HZ / 50000);
  localparam logic [13:0]  CAN_CYC_20K    = 14'(CLK_HZ / 20000);
  localparam logic [13:0]  CAN_CYC_12K5   = 14'(CLK_HZ / 12500);

  function automatic logic [13:0] can_cycles(input logic [3:0] sel);
    case (sel)
      4'h0:    can_cycles = CAN_CYC_1M;
      4'h1:    can_cycles = CAN_CYC_800K;
      4'h2:    can_cycles = CAN_CYC_500K;
      4'h3:    can_cycles = CAN_CYC_250K;
      4'h4:    can_cycles = CAN_CYC_125K;
      4'h5:    can_cycles = CAN_CYC_50K;
      4'h6:    can_cycles = CAN_CYC_20K;
      4'h7:    can_cycles = CAN_CYC_12K5;
      default: can_cycles = 14'h0000;
    endcase
  endfunction : can_cycles

endpackage : node_select_pkg

// file: ip_table_mem.sv
`timescale 1ns/100ps
`default_nettype none

module ip_table_mem #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // write port with byte lanes
  input  wire logic                we,
  input  wire logic [ADDR_W-1:0]   waddr,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic [DATA_W/8-1:0] wstrb,
  // bus read port, enabled
  input  wire logic                re_a,
  input  wire logic [ADDR_W-1:0]   raddr_a,
  output var  logic [DATA_W-1:0]   rdata_a,
  // selector read port, every cycle
  input  wire logic [ADDR_W-1:0]   raddr_b,
  output var  logic [DATA_W-1:0]   rdata_b
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // small table, so a reset clear is cheap and avoids unknown addresses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        mem[i] <= '0;
      end
    end else if (we) begin
      for (int b = 0; b < DATA_W/8; b++) begin
        if (wstrb[b]) begin
          mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      if (re_a) begin
        rdata_a <= mem[raddr_a];
      end
      rdata_b <= mem[raddr_b];
    end
  end

endmodule : ip_table_mem

`default_nettype wire

// file: host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// host pc and dhcp server
// ****
module host_model #(
  parameter int          OFFER_DELAY = 5,
  parameter logic [31:0] OFFER_IP    = 32'hc0a80a21,
  parameter logic [31:0] OFFER_MASK  = 32'hffffff00
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // dhcp
  input  wire logic        dhcp_request,
  output var  logic        dhcp_offer_valid = 1'b0,
  output var  logic [31:0] dhcp_offer_ip = 32'h0,
  output var  logic [31:0] dhcp_offer_mask = 32'h0,
  // packet headers
  output var  logic        rx_valid = 1'b0,
  output var  logic        rx_tcp = 1'b0,
  output var  logic [31:0] rx_src_ip = 32'h0,
  output var  logic [15:0] rx_src_port = 16'h0,
  output var  logic [15:0] rx_dst_port = 16'h0
);
  int wait_cnt = 0;
  logic offer;
  // server is slow on purpose; fields show garbage outside an offer
  assign offer = aresetn && dhcp_request && wait_cnt == OFFER_DELAY;
  always @(posedge aclk) begin
    wait_cnt <= (!aresetn || !dhcp_request) ? 0 : wait_cnt + 32'(wait_cnt < OFFER_DELAY);
    dhcp_offer_valid <= offer;
    dhcp_offer_ip <= offer ? OFFER_IP : ~dhcp_offer_ip;
    dhcp_offer_mask <= offer ? OFFER_MASK : ~dhcp_offer_mask;
  end
  task automatic send(input logic tcp, input logic [31:0] ip, input logic [15:0] sp, dp);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_tcp <= tcp;
    rx_src_ip <= ip;
    rx_src_port <= sp;
    rx_dst_port <= dp;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_src_ip <= ~ip;
    rx_dst_port <= ~dp;
  endtask : send
endmodule : host_model
`default_nettype wire

// file: tb_network_node_address_select.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// bench
// ****
module tb_network_node_address_select;
  import node_select_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, phy_link_ok = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, node_online, bit_rate_valid;
  logic        ip_config_valid, dhcp_request, cmd_valid, cmd_tcp, cmd_drop, owner_valid;
  logic        mdix_swap, link_up, dhcp_offer_valid, rx_valid, rx_tcp;
  logic [1:0]  bresp, rresp, rs;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0, stored_node_high = 3'h0;
  logic [3:0]  wstrb = 4'hf, node_address_switch = 4'h0, bit_rate_switch = 4'h0;
  logic [3:0]  ip_address_switch = 4'h0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [6:0]  node_id;
  logic [13:0] can_bit_cycles;
  logic [15:0] resp_port, rx_src_port, rx_dst_port;
  logic [31:0] wdata = 32'h0, rdata, ip_addr, ip_mask, resp_ip, rd;
  logic [31:0] dhcp_offer_ip, dhcp_offer_mask, rx_src_ip;
  int          fail_count = 0, checked = 0;
  int          cyc[10] = '{100, 125, 200, 400, 800, 2000, 5000, 8000, 0, 0};
  always #5 aclk = ~aclk;
  network_node_address_select #(.MDIX_DWELL_CYCLES(16)) dut (.*);
  host_model host (.*);
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // reset stands in for a power cycle
  task automatic power_up(input logic [3:0] na, input logic [2:0] hi, input logic [3:0] br, ip);
    @(posedge aclk);
    aresetn <= 1'b0;
    node_address_switch <= na;
    stored_node_high <= hi;
    bit_rate_switch <= br;
    ip_address_switch <= ip;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (14) @(posedge aclk);
    #1;
  endtask : power_up
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axr
  task automatic complete_run;
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin
    #50us;
    fail_count++;
    complete_run();
  end
  initial begin
    for (int p = 0; p < 10; p++) begin
      power_up(p[3:0], 3'h0, p[3:0], 4'h0);
      chk({18'h0, can_bit_cycles}, cyc[p]);
      chk({31'h0, bit_rate_valid}, 32'(p < 8));
      chk({31'h0, node_online}, 32'(p != 0));
      chk({ip_addr ^ 32'h0a0a0a0a} | {ip_mask ^ 32'hff000000}, 32'h0);
    end
    // one drive on the bench bus, so its node id is unique
    power_up(4'hf, 3'h7, 4'h2, 4'h1);
    chk({24'h0, node_online, node_id}, 32'hff);
    chk({31'h0, link_up}, 32'h1);
    @(posedge aclk);
    node_address_switch <= 4'h3;
    ip_address_switch <= 4'h0;
    repeat (20) @(posedge aclk);
    #1 chk({25'h0, node_id}, 32'h7f);
    chk(ip_mask, 32'hffff0000);
    axw(8'h44, 32'hc0a80105);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    axr(8'h44);
    chk(rd, 32'hc0a80105);
    repeat (3) @(posedge aclk);
    #1 chk(ip_addr, 32'hc0a80105);
    chk(ip_mask, 32'hffff0000);
    axw(8'h00, 32'h1);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    axr(8'h80);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    host.send(1'b0, 32'h0a000001, 16'h1234, 16'd7775);
    #1 chk({31'h0, cmd_valid}, 32'h1);
    chk(resp_ip ^ {16'h0, resp_port}, 32'h0a001235);
    host.send(1'b1, 32'h0a000002, 16'h4321, 16'd7776);
    #1 chk({30'h0, cmd_drop, cmd_valid}, 32'h2);
    host.send(1'b1, 32'h0a000001, 16'h5555, 16'd7776);
    #1 chk({30'h0, cmd_valid, cmd_tcp}, 32'h3);
    chk({16'h0, resp_port}, 32'h1234);
    host.send(1'b0, 32'h0a000001, 16'h1234, 16'd80);
    #1 chk({30'h0, cmd_valid, cmd_drop}, 32'h0);
    axr(8'h04);
    chk(rd, 32'h0a000001);
    axr(8'h08);
    chk(rd, 32'h00001234);
    // pull the cable: the hunt swaps pairs after one dwell, then relinks crossed
    @(posedge aclk);
    phy_link_ok <= 1'b0;
    repeat (25) @(posedge aclk);
    #1 chk({30'h0, link_up, mdix_swap}, 32'h1);
    @(posedge aclk);
    phy_link_ok <= 1'b1;
    repeat (5) @(posedge aclk);
    #1 chk({30'h0, link_up, mdix_swap}, 32'h3);
    power_up(4'h1, 3'h0, 4'h0, 4'hf);
    chk({30'h0, dhcp_request, owner_valid}, 32'h2);
    repeat (10) @(posedge aclk);
    #1 chk(ip_addr ^ ip_mask, 32'h3f57f521);
    chk({31'h0, ip_config_valid}, 32'h1);
    axr(8'h00);
    chk(rd, 32'h0031f081);
    complete_run();
  end
endmodule : tb_network_node_address_select
`default_nettype wire
